// ==== logic/tsn_bcd_pack.sv ====
// BCD word packer for values keyed into numeral tables
`default_nettype none
module tsn_bcd_pack #(
  parameter int unsigned DIGITS = 8
) (
  input  wire logic [DIGITS*4-1:0] digits_in,
  input  wire logic                negative_in,
  input  wire logic                two_word_in,
  input  wire tsn_pkg::tsn_fmt_t   fmt_in,
  output logic      [15:0]         word_lo_out,
  output logic      [15:0]         word_hi_out,
  output logic                     legal_out
);
  logic [DIGITS*4-1:0] packed_val;

  always_comb begin
    packed_val = digits_in;
    // Digits are keyed as an integer; any point is display-only.
    if (fmt_in == tsn_pkg::TSN_FMT_SIGNED && negative_in) begin
      if (two_word_in) begin
        packed_val[31:28] = tsn_pkg::SIGN_NIBBLE;
      end else begin
        packed_val[15:12] = tsn_pkg::SIGN_NIBBLE;
      end
    end
  end

  // Digit 1 sits in bits 3..0, then upward by nibble.
  assign word_lo_out = packed_val[15:0];
  // Second word carries digits 5..8 in the same order.
  assign word_hi_out = two_word_in ? packed_val[31:16] : 16'h0000;
  // Hex tables take no number entry; unsigned passes as keyed.
  assign legal_out   = (fmt_in != tsn_pkg::TSN_FMT_HEX);
endmodule // tsn_bcd_pack
`default_nettype wire

// ==== logic/tsn_notify.sv ====
// Top: status notify words and strobes of the operator terminal
`default_nettype none
module tsn_notify (
  input  wire logic                 sys_clk_in,
  input  wire logic                 rst_n_in,
  input  wire logic                 screen_change_in,
  input  wire logic [15:0]          screen_bcd_in,
  input  wire logic [15:0]          parent_bcd_in,
  input  wire logic                 overlay_in,
  input  wire logic                 entry_in,
  input  wire logic [11:0]          table_bcd_in,
  input  wire logic [31:0]          entry_digits_in,
  input  wire logic                 entry_negative_in,
  input  wire logic                 entry_two_word_in,
  input  wire tsn_pkg::tsn_fmt_t    entry_fmt_in,
  input  wire tsn_pkg::tsn_area_t   area_sel_in,
  input  wire logic                 ctrl_notified_in,
  output logic [15:0]               current_screen_out,
  output logic [15:0]               update_table_out,
  output logic [15:0]               value_lo_out,
  output logic [15:0]               value_hi_out,
  output logic                      value_two_word_out,
  output logic                      screen_strobe_out,
  output logic                      number_strobe_out,
  output logic                      status_word_valid_out,
  output logic                      entry_rejected_out
);
  typedef enum logic [1:0] {
    TSN_IDLE,
    TSN_WRITTEN,
    TSN_RAISED
  } tsn_state_t;

  typedef struct packed {
    logic [15:0] screen;
    logic [15:0] table_no;
    logic [15:0] lo;
    logic [15:0] hi;
    logic        two;
    logic        scr_strobe;
    logic        num_strobe;
    logic        rejected;
    tsn_state_t  num_state;
  } tsn_regs_t;

  tsn_regs_t st_reg;
  tsn_regs_t st_next;

  logic [15:0] pk_lo;
  logic [15:0] pk_hi;
  logic        pk_legal;
  logic        area_ok;

  // Timer and counter areas cannot hold the notify words.
  function automatic logic area_allowed(input tsn_pkg::tsn_area_t a);
    return !(a == tsn_pkg::TSN_AREA_TIMER ||
             a == tsn_pkg::TSN_AREA_COUNTER);
  endfunction

  assign area_ok = area_allowed(area_sel_in);

  tsn_bcd_pack #(
    .DIGITS (tsn_pkg::VALUE_DIGITS)
  ) u_pack (
    .digits_in   (entry_digits_in),
    .negative_in (entry_negative_in),
    .two_word_in (entry_two_word_in),
    .fmt_in      (entry_fmt_in),
    .word_lo_out (pk_lo),
    .word_hi_out (pk_hi),
    .legal_out   (pk_legal)
  );

  always_comb begin
    st_next = st_reg;
    st_next.rejected = 1'b0;
    // Notification clears first so a same-cycle event wins
    if (ctrl_notified_in) begin
      st_next.scr_strobe = 1'b0;
    end
    // Any change, commanded or stand-alone, refreshes the word unless the area is timer or counter.
    if (screen_change_in && area_ok) begin
      st_next.screen = overlay_in ? parent_bcd_in : screen_bcd_in;
      st_next.scr_strobe = 1'b1;
    end
    unique case (st_reg.num_state)
      TSN_IDLE: begin
      end
      // Data words settled one cycle ahead of the flag.
      TSN_WRITTEN: begin
        st_next.num_strobe = 1'b1;
        st_next.num_state  = TSN_RAISED;
      end
      TSN_RAISED: begin
        if (ctrl_notified_in) begin
          st_next.num_strobe = 1'b0;
          st_next.num_state  = TSN_IDLE;
        end
      end
      // The fourth code of the two-bit state is unused; recover to idle
      default: begin
        st_next.num_strobe = 1'b0;
        st_next.num_state  = TSN_IDLE;
      end
    endcase
    if (entry_in && area_ok) begin
      if (pk_legal) begin
        st_next.lo       = pk_lo;
        st_next.hi       = pk_hi;
        st_next.two      = entry_two_word_in;
        st_next.table_no = {4'h0, table_bcd_in};
        // A new entry keeps the flag up if it is already raised and not notified in this cycle
        st_next.num_state = (st_reg.num_state == TSN_RAISED &&
                             !ctrl_notified_in) ? TSN_RAISED : TSN_WRITTEN;
      end else begin
        st_next.rejected = 1'b1;
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      st_reg <= '{screen: tsn_pkg::WORD_RESET, table_no: tsn_pkg::WORD_RESET,
                  lo: tsn_pkg::WORD_RESET, hi: tsn_pkg::WORD_RESET,
                  two: 1'b0, scr_strobe: 1'b0, num_strobe: 1'b0,
                  rejected: 1'b0, num_state: TSN_IDLE};
    end else begin
      st_reg <= st_next;
    end
  end

  assign current_screen_out    = st_reg.screen;
  assign update_table_out      = st_reg.table_no;
  assign value_lo_out          = st_reg.lo;
  assign value_hi_out          = st_reg.hi;
  assign value_two_word_out    = st_reg.two;
  assign screen_strobe_out     = st_reg.scr_strobe;
  assign number_strobe_out     = st_reg.num_strobe;
  assign status_word_valid_out = area_ok;
  assign entry_rejected_out    = st_reg.rejected;
endmodule // tsn_notify
`default_nettype wire

// ==== logic/tsn_pkg.sv ====
// Package: constants and types for the terminal status notify block
// What this block does
// - Screen change writes new screen number as BCD
// - Stand-alone switching also refreshes screen word
// - Screen strobe sets on change, clears when notified
// - Overlaid screens report the parent screen number
// - Entry stores value, table number, raises strobe
// - Updated table number written as three BCD digits
// - Number strobe clears when notified; controller reads table
// - Single word: digit 1 in low nibble upward
// - Two words: low digits first, high digits next
// - No hex entry; unsigned stored as keyed
// - Signed negative puts F in top digit
// - Values stored as integers, decimal point dropped
`default_nettype none
package tsn_pkg;
  localparam int unsigned SCREEN_DIGITS = 4;
  localparam int unsigned TABLE_DIGITS  = 3;
  localparam int unsigned VALUE_DIGITS  = 8;
  localparam int unsigned WORD_W        = 16;
  localparam int unsigned NIBBLE_W      = 4;
  localparam logic [3:0]  SIGN_NIBBLE   = 4'hF;
  localparam int unsigned STROBE_SCREEN_BIT = 12;
  localparam int unsigned STROBE_NUMBER_BIT = 11;
  localparam logic [15:0] WORD_RESET    = 16'h0000;

  typedef enum logic [1:0] {
    TSN_FMT_HEX,
    TSN_FMT_UNSIGNED,
    TSN_FMT_SIGNED
  } tsn_fmt_t;

  // Areas of controller memory; the notify area may be placed in any but timer and counter
  typedef enum logic [2:0] {
    TSN_AREA_DATA,
    TSN_AREA_IO,
    TSN_AREA_HOLDING,
    TSN_AREA_AUX,
    TSN_AREA_LINK,
    TSN_AREA_TIMER,
    TSN_AREA_COUNTER
  } tsn_area_t;
endpackage
`default_nettype wire

// ==== verification/tsn_notify_bench.sv ====
// Bench: stimulus, queued expectations and verdict for the notify block
`default_nettype none
module tsn_notify_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk_in = 0, rst_n_in = 0, screen_change_in = 0, entry_in = 0;
  logic overlay_in = 0, entry_negative_in = 0, entry_two_word_in = 0;
  logic slow = 0, sp = 0, np = 0, rj, ctrl_notified_in, screen_strobe_out;
  logic number_strobe_out, value_two_word_out, status_word_valid_out;
  logic entry_rejected_out;
  logic [15:0] screen_bcd_in = 0, parent_bcd_in = 0, current_screen_out;
  logic [15:0] update_table_out, value_lo_out, value_hi_out, lo, hi, last;
  logic [11:0] table_bcd_in = 0;
  logic [31:0] entry_digits_in = 0, seed = 32'h8BE6;
  tsn_pkg::tsn_fmt_t entry_fmt_in = tsn_pkg::TSN_FMT_UNSIGNED;
  tsn_pkg::tsn_area_t area_sel_in = tsn_pkg::TSN_AREA_DATA;
  logic [48:0] q[$];
  int mismatches = 0, num_checks = 0, i;
  always #5 sys_clk_in = ~sys_clk_in;
  tsn_notify uut (.*);
  tsn_plc_model plc (.clk_in(sys_clk_in), .rst_n_in, .scr_in(screen_strobe_out),
    .num_in(number_strobe_out), .slow_in(slow), .table_in(update_table_out),
    .notify_out(ctrl_notified_in), .seen_out());
  function automatic logic [31:0] bcd;
    for (int n = 0; n < 8; n++) bcd[n*4 +: 4] = 4'($unsigned($random(seed)) % 10);
  endfunction
  task chk(input logic [48:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // A rising strobe retires the oldest note; words must already be valid
  always @(posedge sys_clk_in) begin
    #2;
    if (screen_strobe_out && !sp) chk(current_screen_out, q.pop_front());
    if (number_strobe_out && !np) chk({value_two_word_out, update_table_out,
      value_lo_out, value_hi_out}, q.pop_front());
    sp = screen_strobe_out;
    np = number_strobe_out;
  end
  task go(input logic s, e);
    @(posedge sys_clk_in);
    #1 screen_change_in = s;
    entry_in = e;
    slow = $random(seed);
    @(posedge sys_clk_in);
    #1 screen_change_in = 0;
    entry_in = 0;
    rj = entry_rejected_out;
    repeat (3) @(posedge sys_clk_in);
    for (i = 0; i < 40 && (screen_strobe_out || number_strobe_out); i++)
      @(posedge sys_clk_in);
    if (i == 40) begin
      mismatches++;
      end_of_test;
    end
    // Leave the edge so the next stimulus never races the sampling edge
    #1;
  endtask
  initial begin
    repeat (5) @(posedge sys_clk_in);
    #1 rst_n_in = 1;
    chk(current_screen_out, 0);
    for (int k = 0; k < 12; k++) begin
      entry_digits_in = bcd();
      {parent_bcd_in, screen_bcd_in} = entry_digits_in;
      table_bcd_in = entry_digits_in[11:0];
      overlay_in = k[0];
      last = overlay_in ? parent_bcd_in : screen_bcd_in;
      q.push_back(last);
      go(1, 0);
      entry_fmt_in = tsn_pkg::tsn_fmt_t'(k % 3);
      entry_two_word_in = k[1];
      entry_negative_in = k[2];
      lo = entry_digits_in[15:0];
      hi = k[1] ? entry_digits_in[31:16] : 16'h0;
      if (k % 3 == 2 && k[2] && k[1]) hi[15:12] = 4'hF;
      if (k % 3 == 2 && k[2] && !k[1]) lo[15:12] = 4'hF;
      if (k % 3 != 0) q.push_back({k[1], 4'h0, table_bcd_in, lo, hi});
      go(0, 1);
      chk(rj, k % 3 == 0);
    end
    for (int a = 5; a < 7; a++) begin
      area_sel_in = tsn_pkg::tsn_area_t'(a);
      screen_bcd_in = 16'h0042;
      go(1, 0);
      chk({status_word_valid_out, current_screen_out}, last);
    end
    chk(q.size(), 0);
    end_of_test;
  end
endmodule // tsn_notify_bench
`default_nettype wire

// ==== verification/tsn_notify_monitor.sv ====
// Checker: timing of the notify words and strobes
`default_nettype none
module tsn_notify_monitor (
  input wire logic               sys_clk_in, rst_n_in, screen_change_in,
  input wire logic               entry_in, overlay_in, ctrl_notified_in,
  input wire logic               screen_strobe_out, number_strobe_out,
  input wire logic               status_word_valid_out, entry_rejected_out,
  input wire logic [15:0]        screen_bcd_in, parent_bcd_in,
  input wire logic [15:0]        current_screen_out, update_table_out,
  input wire logic [15:0]        value_lo_out,
  input wire logic [11:0]        table_bcd_in,
  input wire tsn_pkg::tsn_fmt_t  entry_fmt_in,
  input wire tsn_pkg::tsn_area_t area_sel_in
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (!rst_n_in);
  sequence s_put;
    entry_in && status_word_valid_out && entry_fmt_in != tsn_pkg::TSN_FMT_HEX;
  endsequence
  a_screen_word:
    assert property (screen_change_in && status_word_valid_out |=>
      current_screen_out == ($past(overlay_in) ? $past(parent_bcd_in)
      : $past(screen_bcd_in))) else $error("screen word wrong");
  a_screen_flag:
    assert property (screen_change_in && status_word_valid_out |=>
      screen_strobe_out) else $error("screen strobe missing");
  a_screen_clear:
    assert property (ctrl_notified_in && !screen_change_in |=>
      !screen_strobe_out) else $error("screen strobe stuck");
  a_number_late:
    assert property (s_put ##1 !ctrl_notified_in |=> number_strobe_out)
      else $error("number strobe missing");
  a_table_word:
    assert property (s_put |=> update_table_out == {4'h0,
      $past(table_bcd_in)}) else $error("update table wrong");
  a_number_clear:
    assert property (number_strobe_out && ctrl_notified_in && !entry_in
      |=> !number_strobe_out)
      else $error("number strobe stuck");
  a_hex_refuse:
    assert property (entry_in && status_word_valid_out && entry_fmt_in ==
      tsn_pkg::TSN_FMT_HEX |=> entry_rejected_out && $stable(value_lo_out))
      else $error("hex entry taken");
  a_area_block:
    assert property ((area_sel_in == tsn_pkg::TSN_AREA_TIMER || area_sel_in
      == tsn_pkg::TSN_AREA_COUNTER) == !status_word_valid_out)
      else $error("area check wrong");
endmodule // tsn_notify_monitor
bind tsn_notify tsn_notify_monitor mon (.*);
`default_nettype wire

// ==== verification/tsn_plc_model.sv ====
// Controller model: reads the table on a number strobe, then notifies
`default_nettype none
module tsn_plc_model (
  input wire logic        clk_in, rst_n_in, scr_in, num_in, slow_in,
  input wire logic [15:0] table_in,
  output logic            notify_out,
  output logic [15:0]     seen_out
);
  logic [3:0] cnt_reg;
  // A slow scan leaves the strobe up for several cycles
  always_ff @(posedge clk_in) begin
    notify_out <= 1'h0;
    if (!rst_n_in) cnt_reg <= 4'h0;
    else if ((scr_in || num_in) && !notify_out) begin
      if (num_in) seen_out <= table_in;
      cnt_reg <= cnt_reg + 4'h1;
      if (cnt_reg >= (slow_in ? 4'h6 : 4'h0)) begin
        notify_out <= 1'h1;
        cnt_reg <= 4'h0;
      end
    end
  end
endmodule // tsn_plc_model
`default_nettype wire
